// ==== hsm_pkg.sv ====
// Shared constants and types for the host serial modem port
package hsm_pkg;
  localparam int          DIV_W       = 16;
  localparam logic [3:0]  OVS_LAST    = 4'hF;
  localparam logic [3:0]  OVS_MID     = 4'h7;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  // 250 MHz / (16 * 115200) - 1, a common power-up rate
  localparam logic [15:0] DIV_RST     = 16'h0086;
  localparam int          APB_AW      = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_DATA    = 8'h08;
  localparam logic [7:0]  OFS_IRQ_ST  = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_MSK = 8'h10;
  localparam int          CTRL_PAR_LO = 16;
  localparam int          CTRL_STOP2  = 18;
  localparam int          CTRL_FLOW   = 19;
  localparam int          CTRL_READY  = 20;
  localparam int          CTRL_MRST   = 21;
  localparam int          IRQ_W       = 6;
  localparam int          IRQ_RX      = 0;
  localparam int          IRQ_PERR    = 1;
  localparam int          IRQ_FERR    = 2;
  localparam int          IRQ_OVR     = 3;
  localparam int          IRQ_CALL    = 4;
  localparam int          IRQ_LINK    = 5;
  typedef enum logic [1:0] {HSM_PAR_NONE, HSM_PAR_EVEN, HSM_PAR_ODD} hsm_par_e;
  typedef enum logic [2:0] {HSM_IDLE, HSM_START, HSM_DATA, HSM_PAR, HSM_STOP} hsm_bit_e;
endpackage

// ==== hsm_if.sv ====
// Pin bundle between the serial modem port and its host
`timescale 1ns/1ps
`default_nettype none
interface hsm_if;
  logic txd;
  logic rxd;
  logic rts_n;
  logic cts_n;
  logic host_ready_n;
  logic incoming_call_n;
  logic link_live_n;
  logic mod_reset;
  modport dev (output txd, rts_n, incoming_call_n, link_live_n,
               input  rxd, cts_n, host_ready_n, mod_reset);
  modport host (input  txd, rts_n, incoming_call_n, link_live_n,
                output rxd, cts_n, host_ready_n, mod_reset);
endinterface
`default_nettype wire

// ==== hsm_dev_end.sv ====
// Device end of the serial modem port and the shared UART engine
// Contract
// - Request-to-send low when device accepts characters
// - Clear-to-send low permits sending under flow
// - Lines idle high, handshakes asserted low
// - Rate, parity, stop bits, flow programmable
// - Framing loaded from flash values at start
// - Frame format matches a standard UART
// - Host drives ready input, low means ready
// - Host keeps ready asserted in high-speed mode
// - Ready dropped in high-speed: drop or command
// - Incoming-call output signals remote connection attempt
// - Incoming-call polling enabled by a setting
// - Host sends on device receive line
// - Host receives from device transmit line
// - Module reset high holds device in reset
// - Incoming-call idles high, low on attempt
// - Link-live idles high, low while connected
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module hsm_uart_core #(
  parameter int DIV_W = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             srst,
  input  wire logic [DIV_W-1:0] div,
  input  wire hsm_pkg::hsm_par_e par_mode,
  input  wire logic             stop2,
  input  wire logic             flow_en,
  input  wire logic             tx_valid,
  input  wire logic [7:0]       tx_data,
  output logic                  tx_ready,
  input  wire logic             cts_n_pin,
  input  wire logic             rxd_pin,
  output logic                  txd,
  output logic                  rx_valid,
  output logic [7:0]            rx_data,
  output logic                  rx_perr,
  output logic                  rx_ferr
);
  import hsm_pkg::*;
  logic [1:0]       rx_sync_reg;
  logic [1:0]       cts_sync_reg;
  logic [DIV_W-1:0] tick_cnt_reg;
  hsm_bit_e         tx_st_reg;
  logic [3:0]       tx_ph_reg;
  logic [2:0]       tx_bit_reg;
  logic [7:0]       tx_sh_reg;
  logic             tx_par_reg;
  logic             tx_stop_reg;
  logic             txd_reg;
  hsm_bit_e         rx_st_reg;
  logic [3:0]       rx_ph_reg;
  logic [2:0]       rx_bit_reg;
  logic [7:0]       rx_sh_reg;
  logic             rx_par_reg;
  logic             rx_perr_reg;
  logic             rx_valid_reg;
  logic             rx_ferr_reg;
  logic [7:0]       rx_data_reg;
  logic [7:0]       rx_out_reg;
  logic             rx_pout_reg;
  wire              rxd_s   = rx_sync_reg[1];
  wire              cts_ok  = !flow_en || !cts_sync_reg[1];
  wire              tick    = (tick_cnt_reg >= div);
  wire              tx_end  = tick && (tx_ph_reg == OVS_LAST);
  wire              rx_end  = tick && (rx_ph_reg == OVS_LAST);
  wire              par_odd = (par_mode == HSM_PAR_ODD);

  assign tx_ready = (tx_st_reg == HSM_IDLE) && !srst && cts_ok;
  assign txd      = txd_reg;
  assign rx_valid = rx_valid_reg;
  assign rx_data  = rx_out_reg;
  assign rx_perr  = rx_pout_reg;
  assign rx_ferr  = rx_ferr_reg;

  // Pins cross from outside; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync_reg  <= 2'h3;
      cts_sync_reg <= 2'h3;
    end else begin
      rx_sync_reg  <= {rx_sync_reg[0], rxd_pin};
      cts_sync_reg <= {cts_sync_reg[0], cts_n_pin};
    end
  end

  // Sixteen ticks per bit at the programmed rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt_reg <= '0;
    else if (srst || tick) tick_cnt_reg <= '0;
    else tick_cnt_reg <= tick_cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg   <= HSM_IDLE;
      tx_ph_reg   <= 4'h0;
      tx_bit_reg  <= 3'h0;
      tx_sh_reg   <= 8'h00;
      tx_par_reg  <= 1'b0;
      tx_stop_reg <= 1'b0;
      txd_reg     <= 1'b1;
    end else if (srst) begin
      tx_st_reg <= HSM_IDLE;
      txd_reg   <= 1'b1;
    end else begin
      if (tx_st_reg != HSM_IDLE && tick) tx_ph_reg <= tx_ph_reg + 4'h1;
      case (tx_st_reg)
        HSM_IDLE: begin
          if (tx_valid && tx_ready) begin
            tx_st_reg  <= HSM_START;
            tx_sh_reg  <= tx_data;
            tx_ph_reg  <= 4'h0;
            tx_par_reg <= par_odd;
            txd_reg    <= 1'b0;
          end
        end
        HSM_START, HSM_DATA: begin
          if (tx_end) begin
            if (tx_st_reg == HSM_DATA && tx_bit_reg == BIT_LAST) begin
              tx_st_reg   <= (par_mode == HSM_PAR_NONE) ? HSM_STOP : HSM_PAR;
              txd_reg     <= (par_mode == HSM_PAR_NONE) ? 1'b1 : tx_par_reg;
              tx_stop_reg <= stop2;
            end else begin
              tx_bit_reg <= (tx_st_reg == HSM_START) ? 3'h0 : tx_bit_reg + 3'h1;
              tx_st_reg  <= HSM_DATA;
              txd_reg    <= tx_sh_reg[0];
              tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
              tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
            end
          end
        end
        HSM_PAR: begin
          if (tx_end) begin
            tx_st_reg <= HSM_STOP;
            txd_reg   <= 1'b1;
          end
        end
        default: begin
          if (tx_end) begin
            if (tx_stop_reg) tx_stop_reg <= 1'b0;
            else tx_st_reg <= HSM_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_reg    <= HSM_IDLE;
      rx_ph_reg    <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_sh_reg    <= 8'h00;
      rx_par_reg   <= 1'b0;
      rx_perr_reg  <= 1'b0;
      rx_valid_reg <= 1'b0;
      rx_ferr_reg  <= 1'b0;
      rx_data_reg  <= 8'h00;
      rx_out_reg   <= 8'h00;
      rx_pout_reg  <= 1'b0;
    end else if (srst) begin
      rx_st_reg    <= HSM_IDLE;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (rx_st_reg != HSM_IDLE && tick) rx_ph_reg <= rx_ph_reg + 4'h1;
      case (rx_st_reg)
        HSM_IDLE: begin
          if (!rxd_s) begin
            rx_st_reg <= HSM_START;
            rx_ph_reg <= 4'h0;
          end
        end
        HSM_START: begin
          // Recheck at mid start bit so a glitch is not a frame
          if (tick && rx_ph_reg == OVS_MID) begin
            rx_st_reg   <= rxd_s ? HSM_IDLE : HSM_DATA;
            rx_ph_reg   <= 4'h0;
            rx_bit_reg  <= 3'h0;
            rx_par_reg  <= par_odd;
            rx_perr_reg <= 1'b0;
          end
        end
        HSM_DATA: begin
          if (rx_end) begin
            rx_sh_reg  <= {rxd_s, rx_sh_reg[7:1]};
            rx_par_reg <= rx_par_reg ^ rxd_s;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == BIT_LAST)
              rx_st_reg <= (par_mode == HSM_PAR_NONE) ? HSM_STOP : HSM_PAR;
          end
        end
        HSM_PAR: begin
          if (rx_end) begin
            rx_perr_reg <= rx_par_reg ^ rxd_s;
            rx_st_reg   <= HSM_STOP;
          end
        end
        default: begin
          if (rx_end) begin
            rx_valid_reg <= 1'b1;
            rx_ferr_reg  <= !rxd_s;
            rx_out_reg   <= rx_sh_reg;
            rx_pout_reg  <= rx_perr_reg;
            rx_st_reg    <= HSM_IDLE;
          end
        end
      endcase
    end
  end
endmodule

module hsm_dev_end #(
  parameter int DIV_W = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  hsm_if.dev                    lnk,
  input  wire logic [DIV_W-1:0] flash_div,
  input  wire hsm_pkg::hsm_par_e flash_par,
  input  wire logic             flash_stop2,
  input  wire logic             flash_flow,
  input  wire logic             hs_mode,
  input  wire logic             ri_poll_en,
  input  wire logic             ready_drop_cmd,
  input  wire logic             remote_call,
  input  wire logic             link_up,
  input  wire logic             tx_valid,
  input  wire logic [7:0]       tx_data,
  output logic                  tx_ready,
  output logic                  rx_valid,
  output logic [7:0]            rx_data,
  output logic                  rx_perr,
  output logic                  rx_ferr,
  input  wire logic             rx_ready,
  output logic                  drop_req,
  output logic                  cmd_req,
  output logic                  in_reset
);
  import hsm_pkg::*;
  logic [1:0]       mrst_sync_reg;
  logic [1:0]       rdy_sync_reg;
  logic             rdy_prev_reg;
  logic             cfg_ok_reg;
  logic [DIV_W-1:0] div_reg;
  hsm_par_e         par_reg;
  logic             stop2_reg;
  logic             flow_reg;
  logic             hold_reg;
  logic [7:0]       hold_data_reg;
  logic             hold_perr_reg;
  logic             hold_ferr_reg;
  logic             rts_n_reg;
  logic             call_n_reg;
  logic             live_n_reg;
  logic             drop_reg;
  logic             cmd_reg;
  logic             c_valid;
  logic [7:0]       c_data;
  logic             c_perr;
  logic             c_ferr;
  wire              srst      = mrst_sync_reg[1];
  wire              core_rst  = srst || !cfg_ok_reg;
  wire              ready_n_s = rdy_sync_reg[1];
  wire              ready_lost = ready_n_s && !rdy_prev_reg && hs_mode && link_up;

  hsm_uart_core #(.DIV_W(DIV_W)) hsm_uart_core_inst (
    .pclk      (pclk),
    .presetn   (presetn),
    .srst      (core_rst),
    .div       (div_reg),
    .par_mode  (par_reg),
    .stop2     (stop2_reg),
    .flow_en   (flow_reg),
    .tx_valid  (tx_valid),
    .tx_data   (tx_data),
    .tx_ready  (tx_ready),
    .cts_n_pin (lnk.cts_n),
    .rxd_pin   (lnk.rxd),
    .txd       (lnk.txd),
    .rx_valid  (c_valid),
    .rx_data   (c_data),
    .rx_perr   (c_perr),
    .rx_ferr   (c_ferr)
  );

  assign lnk.rts_n           = rts_n_reg;
  assign lnk.incoming_call_n = call_n_reg;
  assign lnk.link_live_n     = live_n_reg;
  assign rx_valid            = hold_reg;
  assign rx_data             = hold_data_reg;
  assign rx_perr             = hold_perr_reg;
  assign rx_ferr             = hold_ferr_reg;
  assign drop_req            = drop_reg;
  assign cmd_req             = cmd_reg;
  assign in_reset            = core_rst;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrst_sync_reg <= 2'h3;
      rdy_sync_reg  <= 2'h3;
    end else begin
      mrst_sync_reg <= {mrst_sync_reg[0], lnk.mod_reset};
      rdy_sync_reg  <= {rdy_sync_reg[0], lnk.host_ready_n};
    end
  end

  // Framing comes from flash once reset lets go, not from fixed values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ok_reg <= 1'b0;
      div_reg    <= '0;
      par_reg    <= HSM_PAR_NONE;
      stop2_reg  <= 1'b0;
      flow_reg   <= 1'b0;
    end else if (srst) begin
      cfg_ok_reg <= 1'b0;
    end else if (!cfg_ok_reg) begin
      cfg_ok_reg <= 1'b1;
      div_reg    <= flash_div;
      par_reg    <= flash_par;
      stop2_reg  <= flash_stop2;
      flow_reg   <= flash_flow;
    end
  end

  // One-character holding stage; a character landing on a full stage is lost unless rx_ready is high in that cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg      <= 1'b0;
      hold_data_reg <= 8'h00;
      hold_perr_reg <= 1'b0;
      hold_ferr_reg <= 1'b0;
      rts_n_reg     <= 1'b1;
    end else if (core_rst) begin
      hold_reg  <= 1'b0;
      rts_n_reg <= 1'b1;
    end else begin
      if (c_valid && (!hold_reg || rx_ready)) begin
        hold_reg      <= 1'b1;
        hold_data_reg <= c_data;
        hold_perr_reg <= c_perr;
        hold_ferr_reg <= c_ferr;
      end else if (rx_ready) begin
        hold_reg <= 1'b0;
      end
      rts_n_reg <= hold_reg && !rx_ready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_n_reg   <= 1'b1;
      live_n_reg   <= 1'b1;
      rdy_prev_reg <= 1'b1;
      drop_reg     <= 1'b0;
      cmd_reg      <= 1'b0;
    end else if (core_rst) begin
      call_n_reg   <= 1'b1;
      live_n_reg   <= 1'b1;
      rdy_prev_reg <= 1'b1;
      drop_reg     <= 1'b0;
      cmd_reg      <= 1'b0;
    end else begin
      call_n_reg   <= !(remote_call && ri_poll_en);
      live_n_reg   <= !link_up;
      rdy_prev_reg <= ready_n_s;
      drop_reg     <= ready_lost && !ready_drop_cmd;
      cmd_reg      <= ready_lost && ready_drop_cmd;
    end
  end
endmodule
`default_nettype wire

// ==== hsm_host_end.sv ====
// Host end: APB-controlled UART facing the serial modem port
`timescale 1ns/1ps
`default_nettype none
module hsm_host_end (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  hsm_if.host                            lnk,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [hsm_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           irq
);
  import hsm_pkg::*;
  logic [21:0]      ctrl_reg;
  logic [IRQ_W-1:0] ist_reg;
  logic [IRQ_W-1:0] imsk_reg;
  logic             txp_reg;
  logic [7:0]       txb_reg;
  logic             rxf_reg;
  logic [7:0]       rxb_reg;
  logic [1:0]       call_sync_reg;
  logic [1:0]       live_sync_reg;
  logic             call_prev_reg;
  logic             live_prev_reg;
  logic             tx_ready;
  logic             c_valid;
  logic [7:0]       c_data;
  logic             c_perr;
  logic             c_ferr;
  wire              acc       = psel && penable;
  wire              sel_ctrl  = (paddr == OFS_CTRL);
  wire              sel_stat  = (paddr == OFS_STATUS);
  wire              sel_data  = (paddr == OFS_DATA);
  wire              sel_ist   = (paddr == OFS_IRQ_ST);
  wire              sel_imsk  = (paddr == OFS_IRQ_MSK);
  wire              mapped    = sel_ctrl || sel_stat || sel_data || sel_ist || sel_imsk;
  wire              wr        = acc && pwrite && mapped;
  wire              pop       = acc && !pwrite && sel_data;
  wire              call_s    = !call_sync_reg[1];
  wire              live_s    = !live_sync_reg[1];
  wire [IRQ_W-1:0]  ev = {live_s != live_prev_reg, call_s && !call_prev_reg,
                          c_valid && rxf_reg && !pop, c_valid && c_ferr, c_valid && c_perr, c_valid};
  wire [IRQ_W-1:0]  iclr = (wr && sel_ist) ? pwdata[IRQ_W-1:0] : '0;
  wire [31:0]       stat_word = {27'h0, !lnk.rts_n, live_s, call_s, rxf_reg, !txp_reg};

  hsm_uart_core #(.DIV_W(DIV_W)) hsm_uart_core_inst (
    .pclk      (pclk),
    .presetn   (presetn),
    .srst      (1'b0),
    .div       (ctrl_reg[DIV_W-1:0]),
    .par_mode  (hsm_par_e'(ctrl_reg[CTRL_PAR_LO+1:CTRL_PAR_LO])),
    .stop2     (ctrl_reg[CTRL_STOP2]),
    .flow_en   (ctrl_reg[CTRL_FLOW]),
    .tx_valid  (txp_reg),
    .tx_data   (txb_reg),
    .tx_ready  (tx_ready),
    .cts_n_pin (lnk.rts_n),
    .rxd_pin   (lnk.txd),
    .txd       (lnk.rxd),
    .rx_valid  (c_valid),
    .rx_data   (c_data),
    .rx_perr   (c_perr),
    .rx_ferr   (c_ferr)
  );

  assign lnk.cts_n        = rxf_reg;
  assign lnk.host_ready_n = !ctrl_reg[CTRL_READY];
  assign lnk.mod_reset    = ctrl_reg[CTRL_MRST];
  assign pready           = 1'b1;
  assign pslverr          = acc && !mapped;
  assign irq              = |(ist_reg & imsk_reg);
  assign prdata = !mapped  ? 32'h0 :
                  sel_ctrl ? {10'h0, ctrl_reg} :
                  sel_stat ? stat_word :
                  sel_data ? {24'h0, rxb_reg} :
                  sel_ist  ? {26'h0, ist_reg} : {26'h0, imsk_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_sync_reg <= 2'h3;
      live_sync_reg <= 2'h3;
      call_prev_reg <= 1'b0;
      live_prev_reg <= 1'b0;
    end else begin
      call_sync_reg <= {call_sync_reg[0], lnk.incoming_call_n};
      live_sync_reg <= {live_sync_reg[0], lnk.link_live_n};
      call_prev_reg <= call_s;
      live_prev_reg <= live_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= {1'b0, 1'b0, 1'b1, 1'b0, 2'h0, DIV_RST};
      imsk_reg <= '0;
    end else if (wr && sel_ctrl) begin
      ctrl_reg <= pwdata[21:0];
    end else if (wr && sel_imsk) begin
      imsk_reg <= pwdata[IRQ_W-1:0];
    end
  end

  // Events win over a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ist_reg <= '0;
    else ist_reg <= (ist_reg & ~iclr) | ev;
  end

  // Writes to DATA while a byte is still pending are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txp_reg <= 1'b0;
      txb_reg <= 8'h00;
      rxf_reg <= 1'b0;
      rxb_reg <= 8'h00;
    end else begin
      if (txp_reg && tx_ready) txp_reg <= 1'b0;
      else if (wr && sel_data && !txp_reg) begin
        txp_reg <= 1'b1;
        txb_reg <= pwdata[7:0];
      end
      if (c_valid) begin
        rxf_reg <= 1'b1;
        rxb_reg <= c_data;
      end else if (pop) begin
        rxf_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hsm_port_sva.sv ====
// Pin-level checks of the link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module hsm_port_sva #(
  parameter int BIT_CYC = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic txd,
  input wire logic rxd,
  input wire logic rts_n,
  input wire logic cts_n,
  input wire logic host_ready_n,
  input wire logic incoming_call_n,
  input wire logic link_live_n,
  input wire logic mod_reset
);
  int tx_lo, tx_hi, rx_lo;
  // Run lengths per level; the first bit may lose one tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_lo <= 0;
      tx_hi <= 0;
      rx_lo <= 0;
    end else begin
      tx_lo <= txd ? 0 : tx_lo + 1;
      tx_hi <= txd ? tx_hi + 1 : 0;
      rx_lo <= rxd ? 0 : rx_lo + 1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_mrst_held; mod_reset [*6]; endsequence
  sequence s_tx_start; $fell(txd); endsequence
  property p_rst_idle;
    $rose(presetn) |-> txd && rxd && rts_n && !cts_n && incoming_call_n && link_live_n && host_ready_n && !mod_reset;
  endproperty
  property p_mrst_quiet; s_mrst_held |-> txd; endproperty
  property p_tx_lo_min; $rose(txd) |-> tx_lo >= BIT_CYC - 2; endproperty
  property p_tx_lo_max; $rose(txd) |-> tx_lo <= 10 * BIT_CYC; endproperty
  property p_tx_hi_min; s_tx_start |-> tx_hi >= BIT_CYC - 2; endproperty
  property p_rx_lo_min; $rose(rxd) |-> rx_lo >= BIT_CYC - 2; endproperty
  property p_tx_flow; s_tx_start |-> !cts_n; endproperty
  property p_rx_flow; $fell(rxd) |-> !rts_n; endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("pins not idle after reset");
  a_mrst_quiet: assert property (p_mrst_quiet)
    else $error("txd active in module reset");
  a_tx_lo_min: assert property (p_tx_lo_min)
    else $error("txd low run too short");
  a_tx_lo_max: assert property (p_tx_lo_max)
    else $error("txd low run too long");
  a_tx_hi_min: assert property (p_tx_hi_min)
    else $error("txd high run too short");
  a_rx_lo_min: assert property (p_rx_lo_min)
    else $error("rxd low run too short");
  a_tx_flow: assert property (p_tx_flow)
    else $error("device sent while held off");
  a_rx_flow: assert property (p_rx_flow)
    else $error("host sent while held off");
endmodule
`default_nettype wire

// ==== host_serial_modem_port_tb.sv ====
// Bench joining the host and device ends of the serial modem port
`timescale 1ns/1ps
`default_nettype none
module host_serial_modem_port_tb;
  import hsm_pkg::*;
  localparam int BIT_CYC = 32;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        fl_stop2, hs_mode, ri_poll_en, drop_cmd, remote_call, link_up;
  logic        tx_valid, tx_ready, rx_valid, rx_perr, rx_ferr, rx_ready, drop_req, cmd_req, in_reset;
  logic [7:0]  paddr, tx_data, rx_data;
  logic [31:0] pwdata, prdata, rd, pc;
  hsm_par_e    fl_par;
  hsm_par_e    pm [3] = '{HSM_PAR_NONE, HSM_PAR_EVEN, HSM_PAR_ODD};
  logic [7:0]  bt [3] = '{8'h5A, 8'h81, 8'hC3};
  int          miscompares, checks, cyc;
  hsm_if lnk ();
  hsm_dev_end hsm_dev_end_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk.dev), .flash_div(16'h0001),
    .flash_par(fl_par), .flash_stop2(fl_stop2), .flash_flow(1'b1), .hs_mode(hs_mode), .ri_poll_en(ri_poll_en),
    .ready_drop_cmd(drop_cmd), .remote_call(remote_call), .link_up(link_up), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_perr(rx_perr),
    .rx_ferr(rx_ferr), .rx_ready(rx_ready), .drop_req(drop_req), .cmd_req(cmd_req), .in_reset(in_reset));
  hsm_host_end hsm_host_end_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  hsm_port_sva #(.BIT_CYC(BIT_CYC)) hsm_port_sva_inst (.pclk(pclk), .presetn(presetn), .txd(lnk.txd),
    .rxd(lnk.rxd), .rts_n(lnk.rts_n), .cts_n(lnk.cts_n), .host_ready_n(lnk.host_ready_n),
    .incoming_call_n(lnk.incoming_call_n), .link_live_n(lnk.link_live_n), .mod_reset(lnk.mod_reset));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // A hang ends in the report
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] ctrl(hsm_par_e p, logic s2, logic rdy);
    return {11'h0, rdy, 1'b1, s2, p, 16'h0001};
  endfunction
  // Flash values change first, then a module reset makes the device reload them
  task cfg(input hsm_par_e dp, input hsm_par_e hp, input logic s2);
    @(posedge pclk);
    fl_par <= dp;
    fl_stop2 <= s2;
    apb(1'b1, OFS_CTRL, ctrl(hp, s2, 1'b1) | 32'h00200000);
    repeat (4) @(posedge pclk);
    chk({31'h0, in_reset}, 32'h1);
    apb(1'b1, OFS_CTRL, ctrl(hp, s2, 1'b1));
    while (in_reset !== 1'b0) @(posedge pclk);
    chk({30'h0, in_reset, lnk.host_ready_n}, 32'h0);
  endtask
  task h2d(input logic [7:0] b, input logic pe);
    apb(1'b1, OFS_DATA, {24'h0, b});
    while (rx_valid !== 1'b1) @(posedge pclk);
    chk({22'h0, rx_ferr, rx_perr, rx_data}, {23'h0, pe, b});
    rx_ready <= 1'b1;
    @(posedge pclk);
    rx_ready <= 1'b0;
  endtask
  task dev_offer(input logic [7:0] b);
    @(posedge pclk);
    tx_valid <= 1'b1;
    tx_data <= b;
  endtask
  // Valid stands until the edge at which ready is seen high
  task dev_take;
    do @(posedge pclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask
  task dev_send(input logic [7:0] b);
    dev_offer(b);
    dev_take;
  endtask
  task host_byte(input logic [7:0] b);
    do apb(1'b0, OFS_STATUS, 32'h0); while (rd[1] !== 1'b1);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(rd, {24'h0, b});
  endtask
  task t_reset;
    chk({24'h0, lnk.txd, lnk.rxd, lnk.rts_n, lnk.incoming_call_n, lnk.link_live_n, lnk.host_ready_n,
         lnk.cts_n, lnk.mod_reset}, 32'hFC);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h00080086);
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  task t_modes;
    for (int i = 0; i < 3; i++) begin
      cfg(pm[i], pm[i], i[0]);
      h2d(bt[i], 1'b0);
      dev_send(bt[i]);
      host_byte(bt[i]);
    end
  endtask
  task t_perr;
    cfg(HSM_PAR_ODD, HSM_PAR_EVEN, 1'b0);
    apb(1'b1, OFS_IRQ_ST, 32'h3F);
    apb(1'b1, OFS_IRQ_MSK, 32'h2);
    h2d(8'h3C, 1'b1);
    dev_send(8'h3C);
    host_byte(8'h3C);
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    chk({rd[30:0], irq}, 32'h7);
    apb(1'b1, OFS_IRQ_ST, 32'h2);
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    chk({rd[30:0], irq}, 32'h2);
  endtask
  // Second byte must wait while the host leaves the first unread
  task t_flow;
    cfg(HSM_PAR_NONE, HSM_PAR_NONE, 1'b0);
    dev_send(8'h11);
    dev_offer(8'h22);
    repeat (20 * BIT_CYC) @(posedge pclk);
    chk({31'h0, tx_ready}, 32'h0);
    host_byte(8'h11);
    dev_take;
    host_byte(8'h22);
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    chk(rd & 32'h8, 32'h0);
  endtask
  task t_modem;
    @(posedge pclk);
    remote_call <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({31'h0, lnk.incoming_call_n}, 32'h1);
    ri_poll_en <= 1'b1;
    link_up <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({30'h0, lnk.incoming_call_n, lnk.link_live_n}, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h1D);
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    chk(rd & 32'h30, 32'h30);
    remote_call <= 1'b0;
    hs_mode <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      drop_cmd <= c[0];
      apb(1'b1, OFS_CTRL, ctrl(HSM_PAR_NONE, 1'b0, 1'b0));
      pc = 32'h0;
      repeat (20) begin
        @(posedge pclk);
        pc = pc + (cmd_req ? 32'h100 : 32'h0) + (drop_req ? 32'h1 : 32'h0);
      end
      chk(pc, c ? 32'h100 : 32'h1);
      apb(1'b1, OFS_CTRL, ctrl(HSM_PAR_NONE, 1'b0, 1'b1));
      repeat (8) @(posedge pclk);
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, fl_stop2, hs_mode, ri_poll_en, drop_cmd} = 8'h00;
    {remote_call, link_up, tx_valid, rx_ready} = 4'h0;
    {paddr, tx_data, pwdata} = 48'h0;
    fl_par = HSM_PAR_NONE;
    miscompares = 0;
    checks = 0;
    cyc = 0;
    repeat (6) @(posedge pclk);
    t_reset;
    t_modes;
    t_perr;
    t_flow;
    t_modem;
    wrap_up;
  end
endmodule
`default_nettype wire
